// ### shared/ldm_pkg.sv
// Constants, register layout and types of the LED driver mode and fault controller.
`default_nettype none
package ldm_pkg;

  localparam int NCH = 12;
  localparam int DW = 16;
  localparam int AW = 4;

  // Register indexes on the plain register port.
  localparam logic [AW-1:0] REG_CTRL = 4'h0;
  localparam logic [AW-1:0] REG_ENABLE = 4'h1;
  localparam logic [AW-1:0] REG_DIAG = 4'h2;
  localparam logic [AW-1:0] REG_STATUS = 4'h3;
  localparam logic [AW-1:0] REG_FLAGS = 4'h4;
  localparam logic [AW-1:0] REG_FAILED = 4'h5;
  localparam logic [AW-1:0] REG_PROG = 4'h6;

  // Control register fields.
  localparam int CTRL_POR_CLR_BIT = 0;
  localparam int CTRL_FORCE_FS_BIT = 1;
  localparam int CTRL_FS_EXIT_BIT = 2;
  localparam int CTRL_FORCE_ERR_BIT = 3;
  localparam int CTRL_LOCK_BIT = 4;
  localparam int CTRL_WDT_LSB = 8;

  // Status register fields.
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_PIN_BIT = 4;
  localparam int STAT_LOWQ_BIT = 5;
  localparam int STAT_BUS_BIT = 6;

  // Fault flag register fields.
  localparam int FLG_ERR = 0;
  localparam int FLG_NONCRIT = 1;
  localparam int FLG_CRIT = 2;
  localparam int FLG_WDT = 3;
  localparam int FLG_OT = 4;
  localparam int FLG_OUT = 5;
  localparam int NFLG = 6;

  // Reset values and the programming key.
  localparam logic [3:0] WDT_SEL_RST = 4'h3;
  localparam logic LOCK_RST = 1'b0;
  localparam logic [DW-1:0] PROG_KEY = 16'h5a3c;

  // Timing.
  localparam int CLK_NS = 20;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES_DEF = MS_NS / CLK_NS;
  localparam int ERR_PULSE_NS = 50000;
  localparam int ERR_PULSE_CYCLES = (ERR_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int INIT_STEP_MS = 10;

  typedef enum logic [2:0] {
    ST_POR = 3'b000,
    ST_INIT = 3'b001,
    ST_NORMAL = 3'b010,
    ST_SAFE0 = 3'b011,
    ST_SAFE1 = 3'b100,
    ST_OUTPUT_FAILURE_STATE = 3'b101,
    ST_PROG = 3'b110
  } ldm_state_t;

  // Watchdog periods in milliseconds; codes above 11 use the longest period.
  function automatic logic [13:0] ldm_wdt_limit_ms(input logic [3:0] sel);
    logic [13:0] r;
    r = 14'd10000;
    case (sel)
      4'h0: r = 14'd1;
      4'h1: r = 14'd2;
      4'h2: r = 14'd5;
      4'h3: r = 14'd10;
      4'h4: r = 14'd20;
      4'h5: r = 14'd50;
      4'h6: r = 14'd100;
      4'h7: r = 14'd200;
      4'h8: r = 14'd500;
      4'h9: r = 14'd1000;
      4'ha: r = 14'd2000;
      4'hb: r = 14'd5000;
      default: r = 14'd10000;
    endcase
    return r;
  endfunction : ldm_wdt_limit_ms

endpackage : ldm_pkg
`default_nettype wire

// ### src/ldm_wdt.sv
// Communication watchdog counting millisecond ticks between valid frames.
`timescale 1ns/1ps
`default_nettype none
module ldm_wdt (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic run_i,
  input wire logic tick_i,
  input wire logic kick_i,
  input wire logic [3:0] sel_i,
  output logic overflow_o
);
  import ldm_pkg::*;

  logic [13:0] cnt_q;
  logic [13:0] cnt_d;
  logic [13:0] limit;
  logic ovf_q;
  logic ovf_d;

  assign limit = ldm_wdt_limit_ms(sel_i);
  assign overflow_o = ovf_q;

  always_comb begin
    cnt_d = cnt_q;
    ovf_d = 1'b0;
    if (!run_i || kick_i) begin
      cnt_d = 14'h0000;
    end else if (tick_i) begin
      if (cnt_q + 14'h0001 >= limit) begin
        ovf_d = 1'b1;
        cnt_d = 14'h0000;
      end else begin
        cnt_d = cnt_q + 14'h0001;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      cnt_q <= 14'h0000;
      ovf_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      ovf_q <= ovf_d;
    end
  end

endmodule : ldm_wdt
`default_nettype wire

// ### src/ldm_err_pulse.sv
// Timer that holds the error output low for one fixed pulse.
`timescale 1ns/1ps
`default_nettype none
module ldm_err_pulse (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic start_i,
  output logic busy_o
);
  import ldm_pkg::*;

  localparam logic [11:0] LAST = 12'(ERR_PULSE_CYCLES - 1);

  logic [11:0] cnt_q;
  logic busy_q;

  assign busy_o = busy_q;

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      cnt_q <= 12'h000;
      busy_q <= 1'b0;
    end else if (start_i && !busy_q) begin
      cnt_q <= 12'h000;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      cnt_q <= cnt_q + 12'h001;
      busy_q <= (cnt_q != LAST);
    end
  end

endmodule : ldm_err_pulse
`default_nettype wire

// ### src/ldm_mode_ctrl.sv
// Operating-mode state machine, fail-safe handling and error pin control of the LED driver.
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module ldm_mode_ctrl #(
  parameter int MS_CYCLES = ldm_pkg::MS_CYCLES_DEF
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic supply_ok_i,
  input wire logic ldo_ok_i,
  input wire logic [ldm_pkg::AW-1:0] addr_i,
  input wire logic [ldm_pkg::DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [ldm_pkg::DW-1:0] rdata_o,
  input wire logic frame_crc_ok_i,
  input wire logic [3:0] nv_init_delay_sel_i,
  input wire logic [ldm_pkg::NCH-1:0] nv_safe0_channel_set_i,
  input wire logic [ldm_pkg::NCH-1:0] nv_safe1_channel_set_i,
  input wire logic [ldm_pkg::NCH-1:0] nv_channel_diag_enables_i,
  input wire logic nv_shared_shutdown_sel_i,
  input wire logic failsafe_select_pin_i,
  input wire logic ref_high_i,
  input wire logic noncrit_fault_i,
  input wire logic crit_fault_i,
  input wire logic overtemp_i,
  input wire logic [ldm_pkg::NCH-1:0] chan_fault_i,
  input wire logic err_i,
  output logic err_o,
  output logic err_oe_o,
  output logic [ldm_pkg::NCH-1:0] chan_on_o,
  output logic [ldm_pkg::NCH-1:0] diag_active_o,
  output logic serial_enable_o,
  output logic low_current_mode_o,
  output logic [2:0] state_o
);
  import ldm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  ldm_state_t state_q;
  ldm_state_t state_d;
  logic [NCH-1:0] channel_enable_bits_q;
  logic [NCH-1:0] channel_diag_enable_bits_q;
  logic [3:0] watchdog_period_sel_q;
  logic config_lock_bit_q;
  logic [DW-1:0] prog_q;
  logic [NFLG-1:0] flags_q;
  logic [NFLG-1:0] flags_set;
  logic [NFLG-1:0] flags_clr;
  logic [NCH-1:0] failed_q;
  logic [NCH-1:0] new_fail;
  logic err_hold_q;
  logic [DW-1:0] rdata_q;
  logic [15:0] div_q;
  logic ms_tick;
  logic [7:0] init_cnt_q;
  logic [7:0] init_limit;
  logic init_done;
  logic bus_meta_q;
  logic bus_sync_q;
  logic rails_ok;
  logic in_safe;
  logic in_failsafe;
  logic in_normal;
  logic acc_ok;
  logic wr_ctrl;
  logic wr_enable;
  logic wr_diag;
  logic wr_flags;
  logic wr_prog;
  logic cfg_wr_ok;
  logic por_clr_wr;
  logic force_fs_wr;
  logic fs_exit_wr;
  logic force_err_wr;
  logic prog_req;
  logic wdt_ovf;
  logic pulse_busy;
  logic armed;
  logic nc_event;
  logic crit_event;
  logic pulse_start;
  logic enter_init;
  logic enter_safe;
  logic swap_safe;
  logic leave_safe;
  logic shared_fault;
  logic all_off;
  logic [NCH-1:0] safe_set;
  logic [DW-1:0] status_word;
  logic [DW-1:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // State decoding and register port decode.

  assign rails_ok = supply_ok_i && ldo_ok_i;
  assign in_normal = (state_q == ST_NORMAL);
  assign in_safe = (state_q == ST_SAFE0) || (state_q == ST_SAFE1);
  assign in_failsafe = in_safe || (state_q == ST_OUTPUT_FAILURE_STATE);
  assign shared_fault = (state_q == ST_OUTPUT_FAILURE_STATE) && nv_shared_shutdown_sel_i;
  assign low_current_mode_o = shared_fault;
  assign serial_enable_o = (state_q != ST_POR) && !shared_fault;
  assign acc_ok = serial_enable_o;
  assign wr_ctrl = wr_i && acc_ok && (addr_i == REG_CTRL);
  assign wr_enable = wr_i && acc_ok && (addr_i == REG_ENABLE);
  assign wr_diag = wr_i && acc_ok && (addr_i == REG_DIAG);
  assign wr_flags = wr_i && acc_ok && (addr_i == REG_FLAGS);
  assign wr_prog = wr_i && acc_ok && (addr_i == REG_PROG);
  assign cfg_wr_ok = !config_lock_bit_q;
  assign por_clr_wr = wr_ctrl && wdata_i[CTRL_POR_CLR_BIT];
  assign force_fs_wr = wr_ctrl && wdata_i[CTRL_FORCE_FS_BIT];
  assign fs_exit_wr = wr_ctrl && wdata_i[CTRL_FS_EXIT_BIT] && !config_lock_bit_q;
  assign force_err_wr = wr_ctrl && wdata_i[CTRL_FORCE_ERR_BIT];
  assign prog_req = ref_high_i || (prog_q == PROG_KEY);
  assign safe_set = failsafe_select_pin_i ? nv_safe1_channel_set_i : nv_safe0_channel_set_i;

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond enable and initialization delay.

  assign ms_tick = (div_q == 16'(MS_CYCLES - 1));
  assign init_limit = 8'(({4'h0, nv_init_delay_sel_i} + 8'h01) * 8'(INIT_STEP_MS));
  assign init_done = (init_cnt_q >= init_limit);

  always_ff @(posedge mclk_i) begin
    if (!nrst_i || ms_tick) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i || state_q != ST_INIT) begin
      init_cnt_q <= 8'h00;
    end else if (ms_tick && !init_done) begin
      init_cnt_q <= init_cnt_q + 8'h01;
    end
  end

  ldm_wdt u_wdt (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .run_i(in_normal),
    .tick_i(ms_tick),
    .kick_i(frame_crc_ok_i),
    .sel_i(watchdog_period_sel_q),
    .overflow_o(wdt_ovf)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mode state machine.

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_POR: begin
        if (rails_ok) begin
          state_d = ST_INIT;
        end
      end
      ST_INIT: begin
        if (prog_req) begin
          state_d = ST_PROG;
        end else if (por_clr_wr || init_done) begin
          state_d = ST_NORMAL;
        end
      end
      ST_NORMAL: begin
        if (prog_req) begin
          state_d = ST_PROG;
        end else if (wdt_ovf || force_fs_wr) begin
          state_d = failsafe_select_pin_i ? ST_SAFE1 : ST_SAFE0;
        end
      end
      ST_SAFE0, ST_SAFE1: begin
        if (fs_exit_wr) begin
          state_d = ST_NORMAL;
        end else if (new_fail != '0) begin
          state_d = ST_OUTPUT_FAILURE_STATE;
        end else begin
          state_d = failsafe_select_pin_i ? ST_SAFE1 : ST_SAFE0;
        end
      end
      ST_OUTPUT_FAILURE_STATE: begin
        if (fs_exit_wr) begin
          state_d = ST_NORMAL;
        end
      end
      ST_PROG: begin
        if (!prog_req) begin
          state_d = ST_NORMAL;
        end
      end
      default: begin
        state_d = ST_POR;
      end
    endcase
    if (!rails_ok) begin
      state_d = ST_POR;
    end
  end

  assign enter_init = (state_q == ST_POR) && (state_d == ST_INIT);
  assign enter_safe = in_normal && ((state_d == ST_SAFE0) || (state_d == ST_SAFE1));
  assign swap_safe = in_safe && ((state_d == ST_SAFE0) || (state_d == ST_SAFE1))
    && (state_d != state_q);
  assign leave_safe = in_failsafe && (state_d == ST_NORMAL);
  assign state_o = state_q;

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      state_q <= ST_POR;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  always_ff @(posedge mclk_i) begin
    if (!nrst_i || state_q == ST_POR) begin
      channel_enable_bits_q <= '0;
      channel_diag_enable_bits_q <= '0;
      watchdog_period_sel_q <= WDT_SEL_RST;
      config_lock_bit_q <= LOCK_RST;
      prog_q <= '0;
    end else if (enter_init) begin
      channel_enable_bits_q <= '0;
      channel_diag_enable_bits_q <= nv_channel_diag_enables_i;
      watchdog_period_sel_q <= WDT_SEL_RST;
      config_lock_bit_q <= LOCK_RST;
    end else if (enter_safe) begin
      channel_enable_bits_q <= safe_set;
      channel_diag_enable_bits_q <= nv_channel_diag_enables_i;
      watchdog_period_sel_q <= WDT_SEL_RST;
      config_lock_bit_q <= 1'b1;
      prog_q <= '0;
    end else if (swap_safe) begin
      channel_enable_bits_q <= safe_set;
    end else begin
      if (wr_ctrl) begin
        config_lock_bit_q <= wdata_i[CTRL_LOCK_BIT];
        if (cfg_wr_ok) begin
          watchdog_period_sel_q <= wdata_i[CTRL_WDT_LSB +: 4];
        end
      end
      if (wr_enable && cfg_wr_ok && state_q != ST_INIT) begin
        channel_enable_bits_q <= wdata_i[NCH-1:0];
      end
      if (wr_diag && cfg_wr_ok) begin
        channel_diag_enable_bits_q <= wdata_i[NCH-1:0];
      end
      if (wr_prog) begin
        prog_q <= wdata_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault flags and error indication in normal operation.

  assign armed = (flags_q == '0);
  assign nc_event = in_normal && (noncrit_fault_i || force_err_wr);
  assign crit_event = in_normal && crit_fault_i;
  assign pulse_start = nc_event && armed && !crit_event;

  always_comb begin
    flags_set = '0;
    flags_set[FLG_ERR] = nc_event || crit_event || (new_fail != '0);
    flags_set[FLG_NONCRIT] = nc_event;
    flags_set[FLG_CRIT] = crit_event;
    flags_set[FLG_WDT] = in_normal && wdt_ovf;
    flags_set[FLG_OT] = overtemp_i && (state_q != ST_POR);
    flags_set[FLG_OUT] = (new_fail != '0);
    flags_clr = '0;
    if (wr_flags) begin
      flags_clr = wdata_i[NFLG-1:0];
    end
    if (leave_safe) begin
      flags_clr = '1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i || state_q == ST_POR) begin
      flags_q <= '0;
    end else begin
      flags_q <= (flags_q & ~flags_clr) | flags_set;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i || !in_normal || armed) begin
      err_hold_q <= 1'b0;
    end
    if (nrst_i && crit_event && armed) begin
      err_hold_q <= 1'b1;
    end
  end

  ldm_err_pulse u_err_pulse (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .start_i(pulse_start),
    .busy_o(pulse_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Fail-safe output failures and the shared error bus.

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      bus_meta_q <= 1'b1;
      bus_sync_q <= 1'b1;
    end else begin
      bus_meta_q <= err_i;
      bus_sync_q <= bus_meta_q;
    end
  end

  assign all_off = shared_fault && !bus_sync_q;
  assign new_fail = in_failsafe && !all_off
    ? (chan_fault_i & channel_enable_bits_q & channel_diag_enable_bits_q & ~failed_q)
    : '0;

  always_ff @(posedge mclk_i) begin
    if (!nrst_i || !in_failsafe || leave_safe) begin
      failed_q <= '0;
    end else begin
      failed_q <= failed_q | new_fail;
    end
  end

  assign chan_on_o = (overtemp_i || all_off || state_q == ST_POR) ? '0
    : (channel_enable_bits_q & ~failed_q);
  assign diag_active_o = (!(in_normal || in_failsafe) || all_off) ? '0
    : (channel_enable_bits_q & channel_diag_enable_bits_q & ~failed_q);

  assign err_o = 1'b0;
  assign err_oe_o = (state_q == ST_POR)
    || (in_normal && (pulse_busy || err_hold_q))
    || (in_failsafe && (failed_q != '0));

  ////////////////////////////////////////////////////////////////////////////
  // Register read port.

  always_comb begin
    status_word = '0;
    status_word[STAT_STATE_LSB +: 3] = state_q;
    status_word[STAT_PIN_BIT] = failsafe_select_pin_i;
    status_word[STAT_LOWQ_BIT] = shared_fault;
    status_word[STAT_BUS_BIT] = bus_sync_q;
  end

  always_comb begin
    rd_mux = '0;
    unique case (addr_i)
      REG_CTRL: begin
        rd_mux[CTRL_LOCK_BIT] = config_lock_bit_q;
        rd_mux[CTRL_WDT_LSB +: 4] = watchdog_period_sel_q;
      end
      REG_ENABLE: rd_mux[NCH-1:0] = channel_enable_bits_q;
      REG_DIAG: rd_mux[NCH-1:0] = channel_diag_enable_bits_q;
      REG_STATUS: rd_mux = status_word;
      REG_FLAGS: rd_mux[NFLG-1:0] = flags_q;
      REG_FAILED: rd_mux[NCH-1:0] = failed_q;
      REG_PROG: rd_mux = prog_q;
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      rdata_q <= '0;
    end else if (rd_i && acc_ok) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= '0;
    end
  end

  assign rdata_o = rdata_q;

endmodule : ldm_mode_ctrl
`default_nettype wire

// ### testbench/ldm_host_model.sv
// Host stand-in: periodic good-frame pulses and the pulled-up error line.
`timescale 1ns/1ps
`default_nettype none
module ldm_host_model #(
  parameter int GAP = 5
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic talk_i,
  input wire logic err_oe_i,
  output logic frame_ok_o,
  output logic err_bus_o
);
  logic [7:0] gap_q;
  logic wrap_w;
  assign wrap_w = (gap_q == 8'(GAP - 1));
  // The line has a pull-up, so it reads high unless the device sinks it.
  assign err_bus_o = !err_oe_i;
  assign frame_ok_o = talk_i && wrap_w;
  // Reset keeps the frame gap in step with the device's millisecond divider.
  always_ff @(posedge mclk_i) begin
    if (!nrst_i || wrap_w || !talk_i) begin
      gap_q <= 8'h00;
    end else begin
      gap_q <= gap_q + 8'h01;
    end
  end
endmodule : ldm_host_model
`default_nettype wire

// ### testbench/ldm_mode_ctrl_properties.sv
// Port-level timing checks of the mode and fault controller.
`timescale 1ns/1ps
`default_nettype none
module ldm_mode_ctrl_properties (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic supply_ok_i,
  input wire logic ldo_ok_i,
  input wire logic [ldm_pkg::AW-1:0] addr_i,
  input wire logic [ldm_pkg::DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [ldm_pkg::DW-1:0] rdata_o,
  input wire logic ref_high_i,
  input wire logic overtemp_i,
  input wire logic failsafe_select_pin_i,
  input wire logic err_oe_o,
  input wire logic [ldm_pkg::NCH-1:0] chan_on_o,
  input wire logic serial_enable_o,
  input wire logic [2:0] state_o
);
  import ldm_pkg::*;
  logic rails_w;
  logic cw_w;
  logic calm_w;
  logic [2:0] pin_q;
  logic [11:0] low_q;
  assign rails_w = supply_ok_i && ldo_ok_i;
  assign cw_w = wr_i && addr_i == REG_CTRL && rails_w && !ref_high_i;
  assign calm_w = (pin_q == {3{failsafe_select_pin_i}});
  always_ff @(posedge mclk_i) begin
    low_q <= (nrst_i && err_oe_o) ? low_q + 12'h001 : 12'h000;
    pin_q <= {pin_q[1:0], failsafe_select_pin_i};
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  a_rail_loss_por: assert property (!rails_w |=> state_o == ST_POR)
    else $error("rail loss did not reset");
  a_por_exit: assert property (state_o == ST_POR && rails_w |=> state_o == ST_INIT)
    else $error("no init after good rails");
  a_init_dark: assert property (state_o == ST_INIT |-> chan_on_o == '0)
    else $error("channel on during init");
  a_init_read: assert property (state_o == ST_INIT && rails_w && rd_i && addr_i == REG_STATUS
    |=> rdata_o[2:0] == ST_INIT) else $error("read refused in init");
  a_por_clear: assert property (state_o == ST_INIT && cw_w && wdata_i[CTRL_POR_CLR_BIT]
    |=> state_o == ST_NORMAL) else $error("clear did not start normal");
  a_force_safe: assert property (state_o == ST_NORMAL && cw_w && wdata_i[CTRL_FORCE_FS_BIT]
    |-> ##[1:2] state_o inside {ST_SAFE0, ST_SAFE1}) else $error("force ignored");
  a_pin_flag: assert property (rd_i && addr_i == REG_STATUS && serial_enable_o && calm_w
    |=> rdata_o[STAT_PIN_BIT] == pin_q[0]) else $error("pin flag wrong");
  a_err_pulse_len: assert property ($fell(err_oe_o) && state_o == ST_NORMAL
    && $past(state_o) == ST_NORMAL && !$past(wr_i, 2) |-> int'(low_q) == ERR_PULSE_CYCLES)
    else $error("error pulse length wrong");
  a_hot_dark: assert property (overtemp_i ##1 overtemp_i |-> chan_on_o == '0)
    else $error("channel on while hot");
  a_output_failure_state_sink: assert property (state_o == ST_OUTPUT_FAILURE_STATE |-> err_oe_o)
    else $error("failure not sunk on error line");
endmodule : ldm_mode_ctrl_properties
`default_nettype wire

// ### testbench/test_ldm_mode_ctrl.sv
// Self-checking bench for the mode and fault controller.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %0t: got %0h expected %0h", $time, (g), (e)); end end
module test_ldm_mode_ctrl;
  import ldm_pkg::*;
  localparam logic [NCH-1:0] SET0 = 12'h3f0;
  localparam logic [NCH-1:0] SET1 = 12'h00f;
  localparam logic [NCH-1:0] DNV = 12'h0ff;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic supply_ok_i = 1'b1;
  logic ldo_ok_i = 1'b1;
  logic [AW-1:0] addr_i = '0;
  logic [DW-1:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic talk = 1'b1;
  logic shared_sel = 1'b0;
  logic pin = 1'b1;
  logic ref_high_i = 1'b0;
  logic noncrit = 1'b0;
  logic crit = 1'b0;
  logic overtemp_i = 1'b0;
  logic [NCH-1:0] chan_fault = '0;
  logic [3:0] init_sel = 4'h0;
  logic err_o;
  logic [DW-1:0] rdata_o;
  logic frame_ok;
  logic err_bus;
  logic err_oe_o;
  logic [NCH-1:0] chan_on_o;
  logic [NCH-1:0] diag_active_o;
  logic serial_enable_o;
  logic low_current_mode_o;
  logic [2:0] state_o;
  int bad_count = 0;
  int checked = 0;
  int cyc = 0;
  ldm_mode_ctrl #(.MS_CYCLES(10)) i_ldm_mode_ctrl (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .supply_ok_i(supply_ok_i), .ldo_ok_i(ldo_ok_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .frame_crc_ok_i(frame_ok),
    .nv_init_delay_sel_i(init_sel), .nv_safe0_channel_set_i(SET0),
    .nv_safe1_channel_set_i(SET1),
    .nv_channel_diag_enables_i(DNV), .nv_shared_shutdown_sel_i(shared_sel),
    .failsafe_select_pin_i(pin), .ref_high_i(ref_high_i), .noncrit_fault_i(noncrit),
    .crit_fault_i(crit), .overtemp_i(overtemp_i), .chan_fault_i(chan_fault), .err_i(err_bus),
    .err_o(err_o), .err_oe_o(err_oe_o), .chan_on_o(chan_on_o), .diag_active_o(diag_active_o),
    .serial_enable_o(serial_enable_o), .low_current_mode_o(low_current_mode_o),
    .state_o(state_o));
  ldm_host_model i_ldm_host_model (.mclk_i(mclk_i), .nrst_i(nrst_i), .talk_i(talk),
    .err_oe_i(err_oe_o),
    .frame_ok_o(frame_ok), .err_bus_o(err_bus));
  initial begin
    forever #10 mclk_i = ~mclk_i;
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : tick
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask : rd
  task automatic nc_pulse;
    noncrit <= 1'b1;
    tick(1);
    noncrit <= 1'b0;
  endtask : nc_pulse
  // A pulse, when one is due, must be up next cycle and gone 2600 cycles on.
  task automatic err_seen(input logic hi);
    tick(1);
    `CHK(err_oe_o, hi)
    tick(2600);
    `CHK(err_oe_o, 1'b0)
  endtask : err_seen
  initial begin
    logic [DW-1:0] d;
    logic [DW-1:0] f;
    repeat (6) @(posedge mclk_i);
    nrst_i <= 1'b1;
    tick(2);
    rd(REG_STATUS, d);
    `CHK(d[2:0], ST_INIT)
    rd(REG_ENABLE, d);
    `CHK(d[NCH-1:0], 12'h000)
    wr(REG_CTRL, 16'h0001);
    `CHK(state_o, ST_NORMAL)
    $display("test init done");
    wr(REG_ENABLE, 16'h0fff);
    wr(REG_DIAG, 16'h0000);
    wr(REG_CTRL, 16'h0008);
    err_seen(1'b1);
    rd(REG_FLAGS, d);
    `CHK(d[FLG_ERR], 1'b1)
    rd(REG_CTRL, d);
    `CHK(d[CTRL_FORCE_ERR_BIT], 1'b0)
    nc_pulse();
    err_seen(1'b0);
    wr(REG_FLAGS, 16'h003f);
    nc_pulse();
    err_seen(1'b1);
    wr(REG_FLAGS, 16'h003f);
    crit <= 1'b1;
    tick(1);
    crit <= 1'b0;
    tick(3000);
    `CHK(err_oe_o, 1'b1)
    overtemp_i <= 1'b1;
    tick(3);
    `CHK(chan_on_o, 12'h000)
    `CHK(state_o, ST_NORMAL)
    overtemp_i <= 1'b0;
    wr(REG_FLAGS, 16'h003f);
    tick(1);
    `CHK(err_oe_o, 1'b0)
    $display("test error line done");
    wr(REG_CTRL, 16'h0002);
    tick(2);
    `CHK(state_o, ST_SAFE1)
    `CHK(chan_on_o, SET1)
    rd(REG_STATUS, d);
    `CHK(d[STAT_PIN_BIT], 1'b1)
    rd(REG_CTRL, d);
    `CHK(d[CTRL_LOCK_BIT], 1'b1)
    rd(REG_DIAG, d);
    `CHK(d[NCH-1:0], DNV)
    rd(REG_FLAGS, f);
    pin <= 1'b0;
    tick(4);
    `CHK(state_o, ST_SAFE0)
    `CHK(chan_on_o, SET0)
    rd(REG_FLAGS, d);
    `CHK(d, f)
    wr(REG_CTRL, 16'h0004);
    tick(2);
    `CHK(state_o, ST_SAFE0)
    chan_fault <= 12'h020;
    tick(2);
    `CHK(state_o, ST_OUTPUT_FAILURE_STATE)
    `CHK(chan_on_o, 12'h3d0)
    `CHK(diag_active_o, 12'h0d0)
    chan_fault <= 12'h000;
    wr(REG_CTRL, 16'h0300);
    wr(REG_CTRL, 16'h0304);
    tick(2);
    `CHK(state_o, ST_NORMAL)
    rd(REG_FLAGS, d);
    `CHK(d[NFLG-1:0], 6'h00)
    wr(REG_CTRL, 16'h0100);
    tick(60);
    `CHK(state_o, ST_NORMAL)
    shared_sel <= 1'b1;
    talk <= 1'b0;
    tick(40);
    `CHK(state_o, ST_SAFE0)
    $display("test fail-safe done");
    chan_fault <= 12'h100;
    tick(5);
    `CHK(state_o, ST_SAFE0)
    chan_fault <= 12'h010;
    tick(4);
    `CHK(state_o, ST_OUTPUT_FAILURE_STATE)
    `CHK(err_oe_o, 1'b1)
    `CHK(err_o, 1'b0)
    `CHK(low_current_mode_o, 1'b1)
    `CHK(serial_enable_o, 1'b0)
    `CHK(chan_on_o, 12'h000)
    `CHK(diag_active_o, 12'h000)
    chan_fault <= 12'h000;
    supply_ok_i <= 1'b0;
    tick(1);
    `CHK(state_o, ST_POR)
    supply_ok_i <= 1'b1;
    talk <= 1'b1;
    init_sel <= 4'h1;
    tick(185);
    `CHK(state_o, ST_INIT)
    tick(20);
    `CHK(state_o, ST_NORMAL)
    $display("test faults done");
    ref_high_i <= 1'b1;
    tick(3);
    `CHK(state_o, ST_PROG)
    nc_pulse();
    tick(3);
    `CHK(err_oe_o, 1'b0)
    ref_high_i <= 1'b0;
    tick(3);
    `CHK(state_o, ST_NORMAL)
    wr(REG_PROG, PROG_KEY);
    tick(1);
    `CHK(state_o, ST_PROG)
    ldo_ok_i <= 1'b0;
    tick(1);
    `CHK(state_o, ST_POR)
    $display("test modes done");
    complete_run();
  end
endmodule : test_ldm_mode_ctrl
bind ldm_mode_ctrl ldm_mode_ctrl_properties i_ldm_mode_ctrl_properties (.mclk_i(mclk_i),
  .nrst_i(nrst_i), .supply_ok_i(supply_ok_i), .ldo_ok_i(ldo_ok_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ref_high_i(ref_high_i),
  .overtemp_i(overtemp_i), .failsafe_select_pin_i(failsafe_select_pin_i), .err_oe_o(err_oe_o),
  .chan_on_o(chan_on_o), .serial_enable_o(serial_enable_o), .state_o(state_o));
`default_nettype wire
